//--- tbp_pkg.sv
package tbp_pkg;

    localparam int          PINS      = 3;
    localparam int          ADDR_W    = 20;
    localparam int          SYNC_W    = 4;

    // Register indices; the byte address is four times the index
    localparam logic [15:0] DIR_IDX   = 16'hffc9;
    localparam logic [15:0] DATA_IDX  = 16'hffcb;
    localparam logic [19:0] DIR_ADDR  = {2'h0, DIR_IDX, 2'h0};
    localparam logic [19:0] DATA_ADDR = {2'h0, DATA_IDX, 2'h0};

    localparam logic [7:0]  DIR_RST   = 8'h80;
    localparam logic [7:0]  DATA_RST  = 8'h80;
    localparam logic [7:0]  DIR_RD    = 8'hff;
    localparam logic [7:0]  DATA_FIX  = 8'h80;
    localparam logic [7:0]  WCE_ALL   = 8'hff;
    localparam logic [3:0]  SYNC_RST  = 4'h7;

    localparam int          BACK_BIT  = 2;
    localparam int          REQ_BIT   = 1;
    localparam int          WAIT_BIT  = 0;

    typedef enum logic [1:0] {
        SEL_GPIO = 2'b00,
        SEL_BACK = 2'b01,
        SEL_REQ  = 2'b10,
        SEL_WAIT = 2'b11
    } tbp_func_t;

    typedef struct packed {
        logic [PINS-1:0] o;
        logic [PINS-1:0] oe;
    } tbp_pins_t;

    typedef struct packed {
        logic       wr;
        logic       rd_setup;
        logic       dir_hit;
        logic       data_hit;
        logic [7:0] wdata;
    } tbp_bus_t;

endpackage

//--- tbp_sync.sv
`timescale 1ns/1ps
module tbp_sync #(
    parameter int               W   = 4,
    parameter logic [W-1:0]     RST = '0
) (
    input  wire logic           pclk,
    input  wire logic           presetn,
    input  wire logic [W-1:0]   d,
    output logic      [W-1:0]   q
);

    logic [W-1:0] meta_reg;

    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                meta_reg[i] <= RST[i];
                q[i]        <= RST[i];
            end else begin
                meta_reg[i] <= d[i];
                q[i]        <= meta_reg[i];
            end
        end
    end

endmodule // tbp_sync

//--- tbp_apb.sv
`timescale 1ns/1ps
module tbp_apb (
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [tbp_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                pwdata,
    output logic                            pready,
    output logic                            pslverr,
    output tbp_pkg::tbp_bus_t               bus
);

    logic hit_dir;
    logic hit_data;
    logic hit;

    assign hit_dir       = (paddr == tbp_pkg::DIR_ADDR);
    assign hit_data      = (paddr == tbp_pkg::DATA_ADDR);
    assign hit           = hit_dir | hit_data;

    // Zero wait states; read data is captured in the setup cycle
    assign pready        = 1'b1;
    assign pslverr       = psel & penable & ~hit;

    assign bus.wr        = psel & penable & pwrite & hit;
    assign bus.rd_setup  = psel & ~penable & ~pwrite;
    assign bus.dir_hit   = hit_dir;
    assign bus.data_hit  = hit_data;
    assign bus.wdata     = pwdata[7:0];

endmodule // tbp_apb

//--- tbp_port.sv
`timescale 1ns/1ps
// Summary of operation
// - Direction bit 1 drives pin as output, 0 as input; bits 7-3 unused.
// - Direction register is write-only; reads always return all ones.
// - Direction register loads 0x80 on reset and hardware standby only.
// - In software standby, output pins keep driving their previous level.
// - Data register bits 2-0 are driven on pins set as general outputs.
// - Read of data register returns stored bit where direction is 1.
// - Where direction is 0, read returns pin level; bit 7 reads 1.
// - Data bits 6-3 are plain storage and never reach any pin.
// - Data bit 7 ignores writes and always reads 1.
// - Data register loads 0x80 on reset and hardware standby only.
// - Bus release enable turns pin 2 into acknowledge, pin 1 into request.
// - Pin 0 is general I/O only with all wait enables set and select 0.
module tbp_port (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [tbp_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic [tbp_pkg::PINS-1:0]   pin_i,
    output logic      [tbp_pkg::PINS-1:0]   pin_o,
    output logic      [tbp_pkg::PINS-1:0]   pin_oe,
    input  wire logic                       hw_standby,
    input  wire logic                       sw_standby,
    input  wire logic                       bus_release_enable,
    input  wire logic [7:0]                 wait_control_enable_bits,
    input  wire logic                       wait_mode_select_hi,
    input  wire logic                       bus_ack_n,
    output logic                            bus_request_in_n,
    output logic                            wait_in_n
);

    tbp_pkg::tbp_bus_t          bus;
    tbp_pkg::tbp_pins_t         pins_reg;
    tbp_pkg::tbp_pins_t         pins_next;
    tbp_pkg::tbp_func_t         func [tbp_pkg::PINS];

    logic [7:0]                 dir_reg;
    logic [7:0]                 data_reg;
    logic [7:0]                 rd_next;
    logic [7:0]                 prdata_reg;
    logic [tbp_pkg::SYNC_W-1:0] sync_q;
    logic [tbp_pkg::PINS-1:0]   pin_s;
    logic                       hw_stby_s;
    logic                       gpio0_ok;
    logic                       req_reg;
    logic                       wait_reg;

    tbp_apb u_apb (
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .pready  (pready),
        .pslverr (pslverr),
        .bus     (bus)
    );

    // Pins and the standby pin come from outside the clock domain
    tbp_sync #(
        .W   (tbp_pkg::SYNC_W),
        .RST (tbp_pkg::SYNC_RST)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       ({hw_standby, pin_i}),
        .q       (sync_q)
    );

    assign pin_s     = sync_q[tbp_pkg::PINS-1:0];
    assign hw_stby_s = sync_q[tbp_pkg::SYNC_W-1];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir_reg <= tbp_pkg::DIR_RST;
        end else if (hw_stby_s) begin
            dir_reg <= tbp_pkg::DIR_RST;
        end else if (bus.wr && bus.dir_hit) begin
            dir_reg <= bus.wdata | tbp_pkg::DIR_RST;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_reg <= tbp_pkg::DATA_RST;
        end else if (hw_stby_s) begin
            data_reg <= tbp_pkg::DATA_RST;
        end else if (bus.wr && bus.data_hit) begin
            data_reg <= bus.wdata | tbp_pkg::DATA_FIX;
        end
    end

    assign gpio0_ok = (wait_control_enable_bits == tbp_pkg::WCE_ALL)
                      && !wait_mode_select_hi;

    always_comb begin
        func[tbp_pkg::BACK_BIT] = bus_release_enable ? tbp_pkg::SEL_BACK
                                                     : tbp_pkg::SEL_GPIO;
        func[tbp_pkg::REQ_BIT]  = bus_release_enable ? tbp_pkg::SEL_REQ
                                                     : tbp_pkg::SEL_GPIO;
        func[tbp_pkg::WAIT_BIT] = gpio0_ok ? tbp_pkg::SEL_GPIO
                                           : tbp_pkg::SEL_WAIT;
    end

    always_comb begin
        pins_next = '0;
        for (int i = 0; i < tbp_pkg::PINS; i++) begin
            unique case (func[i])
                tbp_pkg::SEL_GPIO: begin
                    pins_next.o[i]  = data_reg[i];
                    pins_next.oe[i] = dir_reg[i];
                end
                tbp_pkg::SEL_BACK: begin
                    pins_next.o[i]  = bus_ack_n;
                    pins_next.oe[i] = 1'b1;
                end
                tbp_pkg::SEL_REQ,
                tbp_pkg::SEL_WAIT: begin
                    pins_next.o[i]  = 1'b0;
                    pins_next.oe[i] = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pins_reg <= '0;
        end else if (hw_stby_s) begin
            pins_reg <= '0;
        end else if (!sw_standby) begin
            pins_reg <= pins_next;
        end
    end

    assign pin_o  = pins_reg.o;
    assign pin_oe = pins_reg.oe;

    // Inactive high when the pin is not in its bus-control role
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_reg <= 1'b1;
        end else if (func[tbp_pkg::REQ_BIT] == tbp_pkg::SEL_REQ) begin
            req_reg <= pin_s[tbp_pkg::REQ_BIT];
        end else begin
            req_reg <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_reg <= 1'b1;
        end else if (func[tbp_pkg::WAIT_BIT] == tbp_pkg::SEL_WAIT) begin
            wait_reg <= pin_s[tbp_pkg::WAIT_BIT];
        end else begin
            wait_reg <= 1'b1;
        end
    end

    assign bus_request_in_n = req_reg;
    assign wait_in_n        = wait_reg;

    always_comb begin
        rd_next      = data_reg;
        rd_next[7]   = 1'b1;
        for (int i = 0; i < tbp_pkg::PINS; i++) begin
            rd_next[i] = dir_reg[i] ? data_reg[i] : pin_s[i];
        end
    end

    // direction reads ones
    // Captured in setup so prdata comes from a flop with no wait state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= '0;
        end else if (bus.rd_setup) begin
            if (bus.dir_hit) begin
                prdata_reg <= tbp_pkg::DIR_RD;
            end else if (bus.data_hit) begin
                prdata_reg <= rd_next;
            end else begin
                prdata_reg <= '0;
            end
        end
    end

    assign prdata = {24'h0, prdata_reg};

    sequence s_rd_dir;
        bus.rd_setup && bus.dir_hit;
    endsequence

    sequence s_rd_data;
        bus.rd_setup && bus.data_hit;
    endsequence

    sequence s_run;
        !hw_stby_s && !sw_standby;
    endsequence

    property p_dir_read;
        @(posedge pclk) disable iff (!presetn)
        s_rd_dir |=> prdata == 32'h0000_00ff;
    endproperty
    a_dir_read: assert property (p_dir_read)
        else $error("direction read not all ones");

    property p_hw_load;
        @(posedge pclk) disable iff (!presetn)
        hw_stby_s |=> dir_reg == 8'h80 && data_reg == 8'h80 && pin_oe == 3'h0;
    endproperty
    a_hw_load: assert property (p_hw_load)
        else $error("hardware standby did not load registers");

    property p_sw_keep;
        @(posedge pclk) disable iff (!presetn)
        sw_standby && !hw_stby_s && !bus.wr |=> $stable(dir_reg) && $stable(data_reg);
    endproperty
    a_sw_keep: assert property (p_sw_keep)
        else $error("registers changed in software standby");

    property p_sw_hold;
        @(posedge pclk) disable iff (!presetn)
        (sw_standby && !hw_stby_s) [*2] |-> $stable(pins_reg);
    endproperty
    a_sw_hold: assert property (p_sw_hold)
        else $error("pins moved in software standby");

    property p_gpio_out;
        @(posedge pclk) disable iff (!presetn)
        s_run and (!bus_release_enable && dir_reg[2])
        |=> pin_oe[2] && pin_o[2] == $past(data_reg[2]);
    endproperty
    a_gpio_out: assert property (p_gpio_out)
        else $error("general output not driving stored bit");

    property p_rd_out;
        @(posedge pclk) disable iff (!presetn)
        s_rd_data and dir_reg[1] |=> prdata[1] == $past(data_reg[1]);
    endproperty
    a_rd_out: assert property (p_rd_out)
        else $error("output pin read not from register");

    property p_rd_in;
        @(posedge pclk) disable iff (!presetn)
        s_rd_data and !dir_reg[0]
        |=> prdata[0] == $past(pin_s[0]) && prdata[7];
    endproperty
    a_rd_in: assert property (p_rd_in)
        else $error("input pin read not from pin");

    property p_bit7;
        @(posedge pclk) disable iff (!presetn)
        bus.wr && bus.data_hit |=> data_reg[7] ##1 data_reg[7];
    endproperty
    a_bit7: assert property (p_bit7)
        else $error("data bit 7 not one");

    property p_back;
        @(posedge pclk) disable iff (!presetn)
        s_run and bus_release_enable
        |=> pin_oe[2] && !pin_oe[1] && pin_o[2] == $past(bus_ack_n);
    endproperty
    a_back: assert property (p_back)
        else $error("bus release pins wrong");

    property p_wait;
        @(posedge pclk) disable iff (!presetn)
        s_run and !gpio0_ok |=> !pin_oe[0] && wait_in_n == $past(pin_s[0]);
    endproperty
    a_wait: assert property (p_wait)
        else $error("wait pin not an input");

    property p_input_off;
        @(posedge pclk) disable iff (!presetn)
        s_run and dir_reg[2:0] == 3'h0 && !bus_release_enable |=> pin_oe == 3'h0;
    endproperty
    a_input_off: assert property (p_input_off)
        else $error("input pin driven");

    property p_dir_only;
        @(posedge pclk) disable iff (!presetn)
        s_run and !bus_release_enable && gpio0_ok
        |=> pin_oe == $past(dir_reg[2:0]);
    endproperty
    a_dir_only: assert property (p_dir_only)
        else $error("direction bit not steering pin");

    property p_upper;
        @(posedge pclk) disable iff (!presetn)
        s_run and !bus_release_enable && gpio0_ok
        |=> pin_o == ($past(data_reg[2:0]) & pin_oe | pin_o & ~pin_oe);
    endproperty
    a_upper: assert property (p_upper)
        else $error("pin output not from data bits 2 to 0");

endmodule // tbp_port

//--- tbp_board.sv
`timescale 1ns/1ps
module tbp_board (
    input  wire logic [tbp_pkg::PINS-1:0] pin_o,
    input  wire logic [tbp_pkg::PINS-1:0] pin_oe,
    input  wire logic [tbp_pkg::PINS-1:0] ext,
    output logic      [tbp_pkg::PINS-1:0] pin_i
);
    // driven pin wins, else board level
    always_comb begin
        for (int i = 0; i < tbp_pkg::PINS; i++) begin
            pin_i[i] = pin_oe[i] ? pin_o[i] : ext[i];
        end
    end
endmodule // tbp_board

//--- tb.sv
`timescale 1ns/1ps
module tb;
    logic        pclk = 1'b0;
    logic        presetn, psel, penable, pwrite, pready, pslverr, e;
    logic [19:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [2:0]  pin_i, pin_o, pin_oe, ext;
    logic        hw_standby, sw_standby, bre, wms, ack_n, req_n, wait_n;
    logic [7:0]  wce;
    int          fails, comparisons, cycles;

    always #50 pclk = ~pclk;

    tbp_port dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pin_i(pin_i), .pin_o(pin_o),
        .pin_oe(pin_oe), .hw_standby(hw_standby), .sw_standby(sw_standby),
        .bus_release_enable(bre), .wait_control_enable_bits(wce),
        .wait_mode_select_hi(wms), .bus_ack_n(ack_n),
        .bus_request_in_n(req_n), .wait_in_n(wait_n));

    tbp_board brd (.pin_o(pin_o), .pin_oe(pin_oe), .ext(ext), .pin_i(pin_i));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [19:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        // No local limit: a slave that never answers ends in the global timeout
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask

    task automatic t_reset;
        apb(1'b0, tbp_pkg::DIR_ADDR, 8'h00);
        chk(r, 32'hff);
        apb(1'b0, tbp_pkg::DATA_ADDR, 8'h00);
        chk(r, 32'h85);
        chk(32'(pin_oe), 32'h0);
        $display("test reset done");
    endtask

    task automatic t_gpio;
        apb(1'b1, tbp_pkg::DATA_ADDR, 8'h35);
        apb(1'b1, tbp_pkg::DIR_ADDR, 8'h07);
        settle(2);
        chk(32'(pin_oe), 32'h7);
        chk(32'(pin_o), 32'h5);
        apb(1'b0, tbp_pkg::DATA_ADDR, 8'h00);
        chk(r, 32'hb5);
        @(posedge pclk);
        ext <= 3'b010;
        apb(1'b1, tbp_pkg::DIR_ADDR, 8'h05);
        settle(3);
        chk(32'(pin_oe), 32'h5);
        apb(1'b0, tbp_pkg::DATA_ADDR, 8'h00);
        chk(r, 32'hb7);
        apb(1'b1, tbp_pkg::DIR_ADDR, 8'hf8);
        settle(3);
        chk(32'(pin_oe), 32'h0);
        apb(1'b0, tbp_pkg::DATA_ADDR, 8'h00);
        chk(r, 32'hb2);
        $display("test gpio done");
    endtask

    task automatic t_release;
        apb(1'b1, tbp_pkg::DIR_ADDR, 8'h07);
        @(posedge pclk);
        bre <= 1'b1;
        ack_n <= 1'b0;
        ext <= 3'b000;
        settle(4);
        chk(32'(pin_oe), 32'h5);
        chk(32'(pin_o[2]), 32'h0);
        chk(32'(req_n), 32'h0);
        apb(1'b1, tbp_pkg::DATA_ADDR, 8'h34);
        settle(2);
        chk(32'({pin_o[2], pin_o[0]}), 32'h0);
        @(posedge pclk);
        ack_n <= 1'b1;
        ext <= 3'b010;
        settle(4);
        chk(32'(pin_o[2]), 32'h1);
        chk(32'(req_n), 32'h1);
        @(posedge pclk);
        bre <= 1'b0;
        settle(2);
        chk(32'(pin_oe), 32'h7);
        $display("test release done");
    endtask

    task automatic t_wait;
        apb(1'b1, tbp_pkg::DIR_ADDR, 8'h06);
        @(posedge pclk);
        wce <= 8'hfe;
        ext <= 3'b000;
        settle(4);
        chk(32'(wait_n), 32'h0);
        chk(32'(pin_oe[0]), 32'h0);
        @(posedge pclk);
        wce <= 8'hff;
        wms <= 1'b1;
        settle(4);
        chk(32'(wait_n), 32'h0);
        @(posedge pclk);
        wms <= 1'b0;
        apb(1'b1, tbp_pkg::DIR_ADDR, 8'h07);
        settle(4);
        chk(32'(wait_n), 32'h1);
        chk(32'(pin_oe), 32'h7);
        $display("test wait done");
    endtask

    task automatic t_standby;
        apb(1'b1, tbp_pkg::DATA_ADDR, 8'h35);
        @(posedge pclk);
        sw_standby <= 1'b1;
        apb(1'b1, tbp_pkg::DATA_ADDR, 8'h32);
        settle(2);
        chk(32'({pin_oe, pin_o}), 32'h3d);
        apb(1'b0, tbp_pkg::DATA_ADDR, 8'h00);
        chk(r, 32'hb2);
        @(posedge pclk);
        sw_standby <= 1'b0;
        settle(2);
        chk(32'(pin_o), 32'h2);
        @(posedge pclk);
        hw_standby <= 1'b1;
        ext <= 3'b011;
        settle(4);
        chk(32'(pin_oe), 32'h0);
        @(posedge pclk);
        hw_standby <= 1'b0;
        settle(4);
        chk(32'(pin_oe), 32'h0);
        apb(1'b0, tbp_pkg::DATA_ADDR, 8'h00);
        chk(r, 32'h83);
        $display("test standby done");
    endtask

    task automatic t_unmapped;
        apb(1'b1, 20'h00000, 8'h5a);
        chk(32'(e), 32'h1);
        apb(1'b0, 20'h00000, 8'h00);
        chk(r, 32'h0);
        apb(1'b0, tbp_pkg::DATA_ADDR, 8'h00);
        chk(32'(e), 32'h0);
        chk(r, 32'h83);
        $display("test unmapped done");
    endtask

    task automatic wrap_up;
        $display("counts: %0d comparisons, %0d mismatches", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Generous ceiling; the sequence needs about 120 cycles
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            wrap_up();
        end
    end

    initial begin
        {presetn, psel, penable, pwrite, hw_standby, sw_standby, bre, wms} = '0;
        {paddr, pwdata, fails, comparisons, cycles} = '0;
        wce = 8'hff;
        ext = 3'b101;
        ack_n = 1'b1;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_gpio();
        t_release();
        t_wait();
        t_standby();
        t_unmapped();
        wrap_up();
    end
endmodule // tb
